// file: inc/sar_link_pkg.sv
package sar_link_pkg;
   // result word
   localparam int RESULT_BITS = 16;
   localparam int CNT_BITS = 6;
   // conversion time bounds, ns, and clock period
   localparam int CLK_PERIOD_NS = 50;
   localparam int CONV_MIN_NS = 500;
   localparam int CONV_MAX_NS = 1000;
   localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   // host serial clock half period in system cycles
   localparam int SCLK_HALF_CYC = 4;
   // host wait after start before reading, covers the longest conversion
   localparam int HOST_WAIT_CYC = CONV_MAX_CYC + 4;
   // reset values
   localparam logic [RESULT_BITS-1:0] RESULT_RESET = 16'h0000;
   // interface modes
   typedef enum logic [1:0]
   {
      MODE_CS = 2'b00,
      MODE_CHAIN = 2'b01
   } mode_type;
endpackage : sar_link_pkg

// file: inc/sar_link_if.sv
`timescale 1ns/1ps
interface sar_link_if;
   logic convert_start_pin;
   logic din;
   logic sclk;
   logic dout_o;
   logic dout_oe_n;
   logic dout;
   // wire level: pulled high when the converter releases its output
   assign dout = dout_oe_n ? 1'b1 : dout_o;
   modport converter (input convert_start_pin, input din, input sclk,
                      output dout_o, output dout_oe_n);
   modport host (output convert_start_pin, output din, output sclk, input dout);
endinterface : sar_link_if

// file: verilog/sync2.sv
`timescale 1ns/1ps
module sync2
(
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // async level and synchronised copy
   input wire logic d_in,
   output logic q_out
);
   logic meta_q;
   // two-stage synchroniser
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         meta_q <= 1'b0;
         q_out <= 1'b0;
      end
      else
      begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end
endmodule : sync2

// file: verilog/sar_converter.sv
`timescale 1ns/1ps
// What this block does
// - conversion start samples both analog inputs
// - inputs disconnected while converting
// - conversion timed by internal clock
// - reconnect inputs, then enter acquisition
// - acquisition powered down, result kept readable
// - conversion length between minimum and maximum
// - serial clock only shifts result out
// - host reads only after conversion completes
// - result is two's complement
// - code span is two reference volts
// - data input high at start: chip-select
// - data input low at start: daisy chain
// - busy indicator bit precedes result
// - six variants, with or without busy
// - daisy chain shifts through like register
// - four-wire start independent of read
// - no reference charge during acquisition
// - start edge releases output, begins conversion
// - lower bits on falling edges, msb first
// - chip-select: release after sixteenth fall (seventeenth with busy) or deselect
module sar_converter
   import sar_link_pkg::*;
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // link
   sar_link_if.converter LINK,
   // analog inputs, already digitised as signed samples
   input wire logic signed [sar_link_pkg::RESULT_BITS-1:0] POSITIVE_ANALOG_INPUT_IN,
   input wire logic signed [sar_link_pkg::RESULT_BITS-1:0] NEGATIVE_ANALOG_INPUT_IN,
   // conversion length select within bounds
   input wire logic [3:0] CONV_TRIM_IN,
   // status
   output logic CONVERTING_OUT,
   output logic INPUTS_CONNECTED_OUT,
   output logic REF_SWITCHING_OUT,
   output logic POWERED_DOWN_OUT,
   output sar_link_pkg::mode_type MODE_OUT
);
   import sar_link_pkg::*;

   typedef enum logic [1:0]
   {
      ST_ACQ = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b10
   } state_type;

   logic cs_s, din_s, sclk_s;
   logic cs_d1_q, din_d1_q, sclk_d1_q;
   logic cs_rise, cs_fall, din_rise, din_fall, sclk_fall;
   state_type state_q;
   logic [CNT_BITS-1:0] conv_cnt_q;
   logic [CNT_BITS-1:0] conv_len_q;
   logic signed [RESULT_BITS-1:0] samp_p_q, samp_n_q;
   logic [RESULT_BITS:0] shift_q;
   logic [CNT_BITS-1:0] bit_cnt_q;
   logic busy_q, mode_chain_q;
   logic oe_n_q, sel_q;
   logic signed [RESULT_BITS:0] diff;
   logic [RESULT_BITS-1:0] code;
   logic cs_sel, deselect, select;

   // synchronise link pins into the system clock
   sync2 u_cs (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(LINK.convert_start_pin), .q_out(cs_s));
   sync2 u_din (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(LINK.din), .q_out(din_s));
   sync2 u_sclk (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(LINK.sclk), .q_out(sclk_s));

   // edge history
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         // match the synchronisers' reset level: no false edge at release
         cs_d1_q <= 1'b0;
         din_d1_q <= 1'b0;
         sclk_d1_q <= 1'b0;
      end
      else
      begin
         cs_d1_q <= cs_s;
         din_d1_q <= din_s;
         sclk_d1_q <= sclk_s;
      end
   end

   assign cs_rise = cs_s & ~cs_d1_q;
   assign cs_fall = ~cs_s & cs_d1_q;
   assign din_rise = din_s & ~din_d1_q;
   assign din_fall = ~din_s & din_d1_q;
   assign sclk_fall = ~sclk_s & sclk_d1_q;

   // chip select level: start pin in three-wire, data input in four-wire
   assign cs_sel = cs_s & din_s;
   assign select = !mode_chain_q && (cs_fall || (din_fall && cs_s));
   assign deselect = !mode_chain_q && (cs_rise || (din_rise && cs_s));

   // conversion sequencer on the internal clock
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         state_q <= ST_ACQ;
         conv_cnt_q <= '0;
         conv_len_q <= CNT_BITS'(CONV_MIN_CYC);
         mode_chain_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_ACQ:
            begin
               if (cs_rise)
               begin
                  state_q <= ST_CONV;
                  conv_cnt_q <= '0;
                  mode_chain_q <= ~din_s;
                  if (CONV_TRIM_IN > 4'(CONV_MAX_CYC - CONV_MIN_CYC))
                     conv_len_q <= CNT_BITS'(CONV_MAX_CYC);
                  else
                     conv_len_q <= CNT_BITS'(CONV_MIN_CYC) + CNT_BITS'(CONV_TRIM_IN);
               end
            end
            ST_CONV:
            begin
               conv_cnt_q <= conv_cnt_q + 1'b1;
               if (conv_cnt_q + 1'b1 >= conv_len_q)
                  state_q <= ST_DONE;
            end
            ST_DONE:
               state_q <= ST_ACQ;
            default:
               state_q <= ST_ACQ;
         endcase
      end
   end

   // input sampling at the start edge
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         samp_p_q <= '0;
         samp_n_q <= '0;
      end
      else if (state_q == ST_ACQ && cs_rise)
      begin
         samp_p_q <= POSITIVE_ANALOG_INPUT_IN;
         samp_n_q <= NEGATIVE_ANALOG_INPUT_IN;
      end
   end

   // signed difference halved: span of two reference volts
   assign diff = (RESULT_BITS+1)'(samp_p_q) - (RESULT_BITS+1)'(samp_n_q);
   assign code = diff[RESULT_BITS:1];

   // output shift register and busy bit
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         shift_q <= {1'b1, RESULT_RESET};
         bit_cnt_q <= '0;
         busy_q <= 1'b0;
      end
      else if (state_q == ST_CONV && conv_cnt_q + 1'b1 >= conv_len_q)
      begin
         // busy when select is low at end of conversion
         busy_q <= mode_chain_q ? ~cs_s : ~cs_sel;
         shift_q <= {1'b0, code};
         bit_cnt_q <= '0;
      end
      else if (state_q == ST_ACQ && sel_q && sclk_fall)
      begin
         // daisy chain feeds the upstream bit in at the bottom
         shift_q <= {shift_q[RESULT_BITS-1:0], mode_chain_q ? din_s : 1'b0};
         bit_cnt_q <= bit_cnt_q + 1'b1;
      end
   end

   // output drive: released at start, enabled on select or busy
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         oe_n_q <= 1'b1;
         sel_q <= 1'b0;
      end
      else if (state_q != ST_ACQ)
      begin
         oe_n_q <= 1'b1;
         sel_q <= 1'b0;
         if (state_q == ST_DONE && busy_q)
         begin
            oe_n_q <= 1'b0; // busy indicator drives low
            sel_q <= 1'b1;
         end
      end
      else if (deselect || cs_rise)
      begin
         // any start edge releases, in chain mode too
         oe_n_q <= 1'b1;
         sel_q <= 1'b0;
      end
      else if (sel_q && sclk_fall &&
               bit_cnt_q == CNT_BITS'(busy_q ? RESULT_BITS : RESULT_BITS - 1))
      begin
         oe_n_q <= mode_chain_q ? 1'b0 : 1'b1;
         sel_q <= mode_chain_q;
      end
      else if (select || (mode_chain_q && !cs_s && !sel_q && bit_cnt_q == '0))
      begin
         oe_n_q <= 1'b0;
         sel_q <= 1'b1;
      end
   end

   // msb first, or the busy bit ahead of it
   assign LINK.dout_o = busy_q ? shift_q[RESULT_BITS] : shift_q[RESULT_BITS-1];
   assign LINK.dout_oe_n = oe_n_q;

   // status: powered down and no reference switching in acquisition
   assign CONVERTING_OUT = (state_q == ST_CONV);
   assign INPUTS_CONNECTED_OUT = (state_q != ST_CONV);
   assign REF_SWITCHING_OUT = (state_q == ST_CONV);
   assign POWERED_DOWN_OUT = (state_q == ST_ACQ);
   assign MODE_OUT = mode_chain_q ? MODE_CHAIN : MODE_CS;
endmodule : sar_converter

// file: verilog/sar_host.sv
`timescale 1ns/1ps
module sar_host
   import sar_link_pkg::*;
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // link
   sar_link_if.host LINK,
   // user request
   input wire logic START_IN,
   input wire logic CHAIN_MODE_IN,
   output logic READY_OUT,
   // result
   output logic [sar_link_pkg::RESULT_BITS-1:0] RESULT_OUT,
   output logic RESULT_VALID_OUT
);
   import sar_link_pkg::*;

   typedef enum logic [2:0]
   {
      H_IDLE = 3'b000,
      H_START = 3'b001,
      H_WAIT = 3'b010,
      H_SEL = 3'b011,
      H_SHIFT = 3'b100,
      H_END = 3'b101
   } hstate_type;

   hstate_type state_q;
   logic [7:0] cnt_q;
   logic [CNT_BITS-1:0] bits_q;
   logic sclk_q, cs_q, din_q, chain_q, dout_s;
   logic [RESULT_BITS-1:0] data_q;
   logic valid_q;

   sync2 u_dout (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(LINK.dout), .q_out(dout_s));

   // read sequence: start, wait out the longest conversion, then shift
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         state_q <= H_IDLE;
         cnt_q <= '0;
         bits_q <= '0;
         sclk_q <= 1'b0;
         cs_q <= 1'b0;
         din_q <= 1'b1;
         chain_q <= 1'b0;
         data_q <= '0;
         valid_q <= 1'b0;
      end
      else
      begin
         valid_q <= 1'b0;
         case (state_q)
            H_IDLE:
            begin
               cs_q <= 1'b0;
               if (START_IN)
               begin
                  chain_q <= CHAIN_MODE_IN;
                  din_q <= ~CHAIN_MODE_IN;
                  cnt_q <= '0;
                  state_q <= H_START;
               end
            end
            H_START:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == 8'h03)
               begin
                  cs_q <= 1'b1; // rising start edge
                  cnt_q <= '0;
                  state_q <= H_WAIT;
               end
            end
            H_WAIT:
            begin
               // hold start high through the longest conversion: no busy bit
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == 8'(HOST_WAIT_CYC))
               begin
                  cnt_q <= '0;
                  state_q <= H_SEL;
               end
            end
            H_SEL:
            begin
               cs_q <= 1'b0; // select, msb appears
               if (chain_q)
                  din_q <= 1'b0;
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == 8'(2 * SCLK_HALF_CYC))
               begin
                  cnt_q <= '0;
                  bits_q <= '0;
                  state_q <= H_SHIFT;
               end
            end
            H_SHIFT:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == 8'(SCLK_HALF_CYC - 1))
               begin
                  cnt_q <= '0;
                  sclk_q <= ~sclk_q;
                  if (sclk_q)
                  begin
                     // capture on the fall: the synchronised copy lags the wire
                     data_q <= {data_q[RESULT_BITS-2:0], dout_s};
                     bits_q <= bits_q + 1'b1;
                     if (bits_q == CNT_BITS'(RESULT_BITS - 1))
                        state_q <= H_END;
                  end
               end
            end
            H_END:
            begin
               // start pin stays low: a rise here would start a conversion
               din_q <= 1'b1;
               valid_q <= 1'b1;
               state_q <= H_IDLE;
            end
            default:
               state_q <= H_IDLE;
         endcase
      end
   end

   assign LINK.convert_start_pin = cs_q;
   assign LINK.din = din_q;
   assign LINK.sclk = sclk_q;
   assign READY_OUT = (state_q == H_IDLE);
   assign RESULT_OUT = data_q;
   assign RESULT_VALID_OUT = valid_q;
endmodule : sar_host

// file: bench/sar_link_checker_sva.sv
`timescale 1ns/1ps
module sar_link_checker
   import sar_link_pkg::*;
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // link wires
   input wire logic convert_start_pin,
   input wire logic din,
   input wire logic sclk,
   input wire logic dout_o,
   input wire logic dout_oe_n
);
   logic start_d_q;
   logic sclk_d_q;
   logic cs_mode_q;
   logic [4:0] fall_cnt_q;
   logic [5:0] since_q;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);
   // previous levels for edge finding
   always_ff @(posedge CLK_IN)
   begin
      start_d_q <= NRST_IN ? convert_start_pin : 1'b0;
      sclk_d_q <= NRST_IN ? sclk : 1'b0;
   end
   // mode taken from data input at start edge
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         cs_mode_q <= 1'b1;
      else if (convert_start_pin && !start_d_q)
         cs_mode_q <= din;
   end
   // serial clock falls within one select frame
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN || convert_start_pin)
         fall_cnt_q <= 5'h00;
      else if (sclk_d_q && !sclk && fall_cnt_q != 5'h1f)
         fall_cnt_q <= fall_cnt_q + 5'h01;
   end
   // cycles since the last start edge, saturating
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN || (convert_start_pin && !start_d_q))
         since_q <= 6'h00;
      else if (since_q != 6'h3f)
         since_q <= since_q + 6'h01;
   end
   sequence s_start;
      $rose(convert_start_pin);
   endsequence
   sequence s_select;
      $fell(convert_start_pin) ##0 cs_mode_q;
   endsequence
   chk_conv_quiet: assert property (s_start |-> ##5 dout_oe_n [*8])
      else $error("output driven during conversion");
   chk_read_spacing: assert property (s_select |-> since_q >= CONV_MAX_CYC)
      else $error("select before longest conversion");
   chk_select_drive: assert property (s_select |-> ##[1:5] !dout_oe_n)
      else $error("msb not driven after select");
   chk_sixteen_release: assert property
      ($rose(fall_cnt_q == 5'h10) ##0 cs_mode_q |-> ##[0:6] dout_oe_n)
      else $error("output held after sixteenth fall");
   chk_deselect_release: assert property
      (convert_start_pin [*6] ##0 cs_mode_q |-> dout_oe_n)
      else $error("output held while deselected");
   chk_data_stable: assert property
      ($rose(sclk) && !dout_oe_n |-> ##1 $stable(dout_o) [*3])
      else $error("data moved away from falling edge");
   chk_sclk_framed: assert property ($changed(sclk) |-> !convert_start_pin)
      else $error("serial clock outside read frame");
   chk_fall_limit: assert property (fall_cnt_q <= 5'h10)
      else $error("more than sixteen falls in frame");
endmodule : sar_link_checker

// file: bench/sar_adc_conversion_interface_test.sv
`timescale 1ns/1ps
module sar_adc_conversion_interface_test;
   import sar_link_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic start = 1'b0;
   logic chain = 1'b0;
   logic signed [RESULT_BITS-1:0] pos = '0;
   logic signed [RESULT_BITS-1:0] neg = '0;
   logic [3:0] trim = 4'h0;
   logic ready, res_valid, converting, connected, ref_sw, powered_down;
   logic [RESULT_BITS-1:0] result;
   logic [RESULT_BITS-1:0] cap = '0;
   mode_type mode;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   sar_link_if link ();
   sar_link_if link_b ();
   // host and converter facing each other, second converter driven by hand
   sar_host i_sar_host (.CLK_IN(clk), .NRST_IN(nrst), .LINK(link.host), .START_IN(start),
      .CHAIN_MODE_IN(chain), .READY_OUT(ready), .RESULT_OUT(result),
      .RESULT_VALID_OUT(res_valid));
   sar_converter i_sar_converter (.CLK_IN(clk), .NRST_IN(nrst), .LINK(link.converter),
      .POSITIVE_ANALOG_INPUT_IN(pos), .NEGATIVE_ANALOG_INPUT_IN(neg), .CONV_TRIM_IN(trim),
      .CONVERTING_OUT(converting), .INPUTS_CONNECTED_OUT(connected),
      .REF_SWITCHING_OUT(ref_sw), .POWERED_DOWN_OUT(powered_down), .MODE_OUT(mode));
   sar_converter i_sar_converter_b (.CLK_IN(clk), .NRST_IN(nrst), .LINK(link_b.converter),
      .POSITIVE_ANALOG_INPUT_IN(pos), .NEGATIVE_ANALOG_INPUT_IN(neg), .CONV_TRIM_IN(4'h0),
      .CONVERTING_OUT(), .INPUTS_CONNECTED_OUT(), .REF_SWITCHING_OUT(),
      .POWERED_DOWN_OUT(), .MODE_OUT());
   sar_link_checker i_sar_link_checker (.CLK_IN(clk), .NRST_IN(nrst),
      .convert_start_pin(link.convert_start_pin), .din(link.din), .sclk(link.sclk),
      .dout_o(link.dout_o), .dout_oe_n(link.dout_oe_n));
   // system clock
   always #25 clk = ~clk;
   // wire bits as the host would capture them
   always @(posedge link.sclk)
      if (link.dout_oe_n === 1'b0)
         cap <= {cap[RESULT_BITS-2:0], link.dout};
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word
   task automatic check_flag(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask : check_flag
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // one start and read through the host, judged at every phase
   task automatic run_conv(input logic [15:0] p, input logic [15:0] n, input logic [3:0] t,
         input logic ch, input logic disturb);
      logic [16:0] diff;
      int len;
      int want;
      diff = {p[15], p} - {n[15], n};
      want = (CONV_MIN_CYC + t > CONV_MAX_CYC) ? CONV_MAX_CYC : CONV_MIN_CYC + t;
      pos = p;
      neg = n;
      trim = t;
      chain = ch;
      for (int i = 0; i < 200 && ready !== 1'b1; i++) tick(1);
      start = 1'b1;
      tick(1);
      start = 1'b0;
      for (int i = 0; i < 50 && converting !== 1'b1; i++) tick(1);
      if (disturb)
      begin
         pos = ~p;
         neg = p;
      end
      check_flag("inputs connected", 1'b0, connected);
      check_flag("ref switching", 1'b1, ref_sw);
      check_flag("powered down", 1'b0, powered_down);
      check_flag("dout released", 1'b1, link.dout_oe_n);
      len = 0;
      while (converting === 1'b1 && len < 40)
      begin
         len++;
         tick(1);
      end
      check_word("conv length", 16'(want), 16'(len));
      check_flag("acq connected", 1'b1, connected);
      tick(1);
      check_flag("acq powered down", 1'b1, powered_down);
      check_flag("acq ref switching", 1'b0, ref_sw);
      for (int i = 0; i < 300 && res_valid !== 1'b1; i++) tick(1);
      check_word("result", diff[16:1], result);
      check_word("mode", ch ? 16'(MODE_CHAIN) : 16'(MODE_CS), 16'(mode));
      if (!ch)
      begin
         check_word("wire word", diff[16:1], cap);
         tick(4);
         check_flag("frame end released", 1'b1, link.dout_oe_n);
      end
   endtask : run_conv
   task automatic t_cs_read;
      run_conv(16'h4000, 16'hc000, 4'h0, 1'b0, 1'b0);
   endtask : t_cs_read
   task automatic t_negative_full;
      run_conv(16'h8000, 16'h7fff, 4'h5, 1'b0, 1'b0);
   endtask : t_negative_full
   task automatic t_trim_cap;
      run_conv(16'h7fff, 16'h8000, 4'hf, 1'b0, 1'b0);
   endtask : t_trim_cap
   task automatic t_sample_held;
      run_conv(16'h0123, 16'h0100, 4'h3, 1'b0, 1'b1);
   endtask : t_sample_held
   task automatic t_chain;
      run_conv(16'hff00, 16'h0100, 4'h2, 1'b1, 1'b0);
      run_conv(16'h0010, 16'h0000, 4'h1, 1'b0, 1'b0);
   endtask : t_chain
   // four-wire: start held high, data input selects and deselects
   task automatic t_four_wire;
      pos = 16'h0000;
      neg = 16'h8000;
      link_b.din = 1'b1;
      link_b.convert_start_pin = 1'b1;
      tick(HOST_WAIT_CYC);
      link_b.din = 1'b0;
      tick(4);
      check_flag("four wire driven", 1'b0, link_b.dout_oe_n);
      check_flag("four wire msb", 1'b0, link_b.dout);
      link_b.sclk = 1'b1;
      tick(4);
      link_b.sclk = 1'b0;
      tick(4);
      check_flag("four wire second bit", 1'b1, link_b.dout);
      link_b.din = 1'b1;
      tick(4);
      check_flag("four wire deselect", 1'b1, link_b.dout_oe_n);
      link_b.convert_start_pin = 1'b0;
      tick(2);
   endtask : t_four_wire
   // select during conversion: clocks ignored, busy bit at the end
   task automatic t_early_read;
      link_b.convert_start_pin = 1'b1;
      tick(4);
      link_b.convert_start_pin = 1'b0;
      link_b.sclk = 1'b1;
      tick(2);
      link_b.sclk = 1'b0;
      tick(2);
      check_flag("early read released", 1'b1, link_b.dout_oe_n);
      tick(HOST_WAIT_CYC);
      check_flag("busy driven", 1'b0, link_b.dout_oe_n);
      check_flag("busy level", 1'b0, link_b.dout);
      link_b.convert_start_pin = 1'b1;
      tick(6);
      check_flag("deselect released", 1'b1, link_b.dout_oe_n);
   endtask : t_early_read
   // main sequence
   initial
   begin
      link_b.convert_start_pin = 1'b0;
      link_b.din = 1'b1;
      link_b.sclk = 1'b0;
      tick(20);
      nrst = 1'b1;
      t_cs_read();
      t_negative_full();
      t_trim_cap();
      t_sample_held();
      t_chain();
      t_four_wire();
      t_early_read();
      end_of_test();
   end
endmodule : sar_adc_conversion_interface_test
